/* File: src/sarmux_ctrl.sv */
// control logic of an 8-bit successive-approximation converter with 16-input mux
`include "sarmux_regs.svh"
`default_nettype none
module sarmux_ctrl #(
    parameter int RES_BITS = `SARMUX_RES_BITS,
    parameter int CHANNELS = `SARMUX_CHANNELS
) (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 nrst,
    // channel select
    input  wire logic [3:0]           chan_sel,
    input  wire logic                 addr_strobe,
    input  wire logic                 mux_enable,
    output var  logic [CHANNELS-1:0]  chan_on,
    // conversion
    input  wire logic                 conversion_start_pulse,
    input  wire logic                 comp_above,
    output var  logic [7:0]           trial_code,
    output var  logic                 conv_done,
    // result pins
    input  wire logic                 out_enable,
    output var  logic [7:0]           result_out,
    output var  logic [7:0]           result_oe,
    // interrupt registers
    input  wire logic [1:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output var  logic [7:0]           reg_rdata,
    output var  logic                 irq
);
    sarmux_pkg::sarmux_state_e state;
    sarmux_pkg::sarmux_state_e next_state;
    logic [7:0]          approx_bit_register;
    logic [7:0]          next_approx;
    logic [7:0]          result_reg;
    logic [2:0]          step;
    logic [3:0]          sel_latch;
    logic                strobe_d;
    logic                start_d;
    logic [1:0]          irq_status;
    logic [1:0]          irq_mask;
    sarmux_pkg::sarmux_out_s pins;

    wire strobe_rise = addr_strobe & ~strobe_d;
    wire start_rise  = conversion_start_pulse & ~start_d;
    wire start_fall  = ~conversion_start_pulse & start_d;
    wire in_step     = (state == sarmux_pkg::SARMUX_STEP);
    wire last_step   = in_step && (step == `SARMUX_STEP_LSB);
    // bit under test kept if the comparator says the input is above the trial
    wire [7:0] step_bit  = 8'h01 << step;
    wire [7:0] kept      = comp_above ? approx_bit_register : (approx_bit_register & ~step_bit);
    wire [7:0] next_try  = last_step ? kept : (kept | (step_bit >> 1));
    wire done_event      = (state == sarmux_pkg::SARMUX_LOAD);
    wire [1:0] irq_events = {start_rise && (state != sarmux_pkg::SARMUX_IDLE), done_event};
    wire wr_status = reg_wr && (reg_addr == 2'h0);
    wire wr_mask   = reg_wr && (reg_addr == 2'h1);
    wire [7:0] rd_mux = (reg_addr == 2'h0) ? {6'h00, irq_status} :
                        (reg_addr == 2'h1) ? {6'h00, irq_mask} :
                        (reg_addr == 2'h2) ? result_reg : `SARMUX_ZERO_RES;

    // mux switch decode, one per input
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    chan_on[gi] <= 1'b0;
                end else begin
                    chan_on[gi] <= mux_enable && (sel_latch == 4'(gi));
                end
            end
        end
    endgenerate

    always_comb begin
        next_state  = state;
        next_approx = approx_bit_register;
        if (start_rise) begin
            next_state  = sarmux_pkg::SARMUX_ARMED;
            next_approx = `SARMUX_ZERO_RES;
        end else begin
            case (state)
                sarmux_pkg::SARMUX_IDLE: begin
                    next_state = sarmux_pkg::SARMUX_IDLE;
                end
                sarmux_pkg::SARMUX_ARMED: begin
                    if (start_fall) begin
                        next_state  = sarmux_pkg::SARMUX_STEP;
                        next_approx = 8'h80;
                    end
                end
                sarmux_pkg::SARMUX_STEP: begin
                    next_approx = next_try;
                    if (last_step) begin
                        next_state = sarmux_pkg::SARMUX_LOAD;
                    end
                end
                sarmux_pkg::SARMUX_LOAD: begin
                    next_state = sarmux_pkg::SARMUX_IDLE;
                end
                default: begin
                    next_state = sarmux_pkg::SARMUX_IDLE;
                end
            endcase
        end
    end

    assign pins.data = result_reg;
    assign pins.oe   = {8{out_enable}};

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state               <= sarmux_pkg::SARMUX_IDLE;
            approx_bit_register <= `SARMUX_ZERO_RES;
            step                <= `SARMUX_STEP_MSB;
            strobe_d            <= 1'b0;
            start_d             <= 1'b0;
        end else begin
            state               <= next_state;
            approx_bit_register <= next_approx;
            strobe_d            <= addr_strobe;
            start_d             <= conversion_start_pulse;
            // step counts down from the top bit during the approximation
            step <= in_step ? (step - 3'h1) : `SARMUX_STEP_MSB;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sel_latch <= `SARMUX_ZERO_SEL;
        end else if (strobe_rise) begin
            sel_latch <= chan_sel;
        end
    end

    // result loads at the last step; done follows one clock later from the load state
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            result_reg <= `SARMUX_ZERO_RES;
        end else if (last_step) begin
            result_reg <= kept;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            conv_done <= 1'b0;
        end else if (start_rise) begin
            conv_done <= 1'b0;
        end else if (done_event) begin
            conv_done <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            trial_code <= `SARMUX_ZERO_RES;
            result_out <= `SARMUX_ZERO_RES;
            result_oe  <= `SARMUX_ZERO_RES;
        end else begin
            trial_code <= next_approx;
            result_out <= pins.data;
            result_oe  <= pins.oe;
        end
    end

    // interrupt status: set wins over write-one-to-clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_status <= 2'h0;
            irq_mask   <= 2'h0;
            reg_rdata  <= `SARMUX_ZERO_RES;
            irq        <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~(wr_status ? reg_wdata[1:0] : 2'h0)) | irq_events;
            if (wr_mask) begin
                irq_mask <= reg_wdata[1:0];
            end
            reg_rdata <= reg_rd ? rd_mux : `SARMUX_ZERO_RES;
            irq       <= |(irq_status & irq_mask);
        end
    end
endmodule
`default_nettype wire

/* File: src/sarmux_regs.svh */
// constants of the successive-approximation converter control block
// Notes on behaviour
// - channel select is captured on the strobe's rising edge and held until the next
// - with the mux enabled, the input whose index equals the latched select is on
// - with the mux disabled, all sixteen inputs are off regardless of select
// - result register loads one converter clock before done rises
// - result is positive true: larger input gives larger code
// - eight-bit result built by setting and testing one bit per step
// - result pins are driven only while output enable is high
// - conversion is monotonic; code never falls as input rises
// - start rising edge clears the approximation register; its fall begins conversion
// - a new start abandons any conversion in progress
// - done goes low within 0 to 8 converter clocks after start rises
// - exactly eight approximation steps per conversion
`ifndef SARMUX_REGS_SVH
`define SARMUX_REGS_SVH
`define SARMUX_RES_BITS     8
`define SARMUX_SEL_BITS     4
`define SARMUX_CHANNELS     16
`define SARMUX_STEP_MSB     3'h7
`define SARMUX_STEP_LSB     3'h0
`define SARMUX_ZERO_RES     8'h00
`define SARMUX_ZERO_SEL     4'h0
`define SARMUX_IRQ_DONE     0
`define SARMUX_IRQ_RESTART  1
`define SARMUX_IRQ_BITS     2
`endif

/* File: src/sarmux_pkg.sv */
// types of the successive-approximation converter control block
`default_nettype none
package sarmux_pkg;
    typedef enum logic [1:0] {
        SARMUX_IDLE  = 2'b00,
        SARMUX_ARMED = 2'b01,
        SARMUX_STEP  = 2'b10,
        SARMUX_LOAD  = 2'b11
    } sarmux_state_e;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] oe;
    } sarmux_out_s;
endpackage
`default_nettype wire

/* File: dv/sarmux_ctrl_monitor.sv */
// assertion checker for the converter control block
`default_nettype none
module sarmux_ctrl_monitor #(
    parameter int CHANNELS = 16
) (
    // clock and reset
    input wire logic                clock,
    input wire logic                nrst,
    // watched ports
    input wire logic                mux_enable,
    input wire logic [CHANNELS-1:0] chan_on,
    input wire logic                conversion_start_pulse,
    input wire logic [7:0]          trial_code,
    input wire logic                conv_done,
    input wire logic                out_enable,
    input wire logic [7:0]          result_out,
    input wire logic [7:0]          result_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // eight quiet cycles after the fall, then one more before done is due
    sequence run_s;
        $fell(conversion_start_pulse) ##1 !conversion_start_pulse[*8];
    endsequence
    chk_done_drop: assert property ($rose(conversion_start_pulse) |=> !conv_done)
        else $error("done not low after start");
    chk_first_trial: assert property ($fell(conversion_start_pulse) |=> trial_code == 8'h80)
        else $error("trial not msb after start fall");
    chk_step_count: assert property (run_s ##1 !conversion_start_pulse |-> !conv_done ##1 conv_done)
        else $error("done not after eight steps");
    chk_done_hold: assert property (conv_done && !$rose(conversion_start_pulse) |=> conv_done)
        else $error("done dropped without start");
    chk_result_hold: assert property (conv_done && $past(conv_done) |-> $stable(result_out))
        else $error("result moved while done");
    // outputs still hold reset values one edge after release
    chk_pins_on: assert property (out_enable && $past(nrst) |=> result_oe == 8'hff)
        else $error("pins not driven");
    chk_pins_off: assert property (!out_enable |=> result_oe == 8'h00)
        else $error("pins not released");
    chk_mux_off: assert property (!mux_enable |=> chan_on == '0)
        else $error("switch on while mux off");
    chk_mux_one: assert property (mux_enable && $past(nrst) |=> $onehot(chan_on))
        else $error("not one switch on");
endmodule
bind sarmux_ctrl sarmux_ctrl_monitor #(.CHANNELS(CHANNELS)) u_mon (.clock, .nrst, .mux_enable,
    .chan_on, .conversion_start_pulse, .trial_code, .conv_done, .out_enable, .result_out,
    .result_oe);
`default_nettype wire

/* File: dv/sarmux_ana_model.sv */
// comparator and analog inputs seen by the control block
`default_nettype none
module sarmux_ana_model (
    // switches and ladder
    input wire logic [15:0] chan_on,
    input wire logic [7:0]  trial_code,
    input wire logic [7:0]  ext_level,
    // decision
    output logic            comp_above
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] level;
    // input i sits at code i*17; ext level stands in when all switches open
    always_comb begin
        level = ext_level;
        for (int i = 0; i < 16; i++) begin
            if (chan_on[i]) level = 8'(i * 17);
        end
    end
    assign comp_above = level >= trial_code;
endmodule
`default_nettype wire

/* File: dv/sarmux_ctrl_test.sv */
// self-checking bench for the converter control block
`default_nettype none
module sarmux_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, nrst, addr_strobe, mux_enable, start, comp_above, out_enable;
    logic        reg_wr, reg_rd, conv_done, irq;
    logic [3:0]  chan_sel;
    logic [1:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, trial_code, result_out, result_oe;
    logic [15:0] chan_on;
    int          n_fail, checks;
    sarmux_ctrl DUT (.clock, .nrst, .chan_sel, .addr_strobe, .mux_enable, .chan_on,
        .conversion_start_pulse(start), .comp_above, .trial_code, .conv_done, .out_enable,
        .result_out, .result_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
    sarmux_ana_model u_ana (.chan_on, .trial_code, .ext_level(8'h3c), .comp_above);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
        @(posedge clock);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // nine clocks high covers the eight-clock minimum width
    task automatic start_pulse;
        @(posedge clock);
        start <= 1'b1;
        wait_n(2);
        chk("done drop", 0, conv_done);
        wait_n(7);
        start <= 1'b0;
    endtask
    task automatic conv(input logic [7:0] exp, input string what);
        start_pulse();
        for (int i = 0; i <= 40; i++) begin
            if (i == 40) begin
                n_fail++;
                end_sim();
            end
            wait_n(1);
            if (conv_done === 1'b1) break;
        end
        chk(what, exp, result_out);
    endtask
    task automatic t_channels;
        for (int c = 0; c < 16; c += 5) begin
            @(posedge clock);
            {chan_sel, addr_strobe} <= {4'(c), 1'b1};
            @(posedge clock);
            addr_strobe <= 1'b0;
            wait_n(3);
            chk("chan_on", 16'h1 << c, chan_on);
            conv(8'(c * 17), "result");
        end
        chan_sel <= 4'h9;
        wait_n(3);
        chk("held select", 16'h8000, chan_on);
    endtask
    task automatic t_mux_off;
        mux_enable <= 1'b0;
        wait_n(2);
        chk("mux off", 0, chan_on);
        conv(8'h3c, "ext result");
        mux_enable <= 1'b1;
    endtask
    task automatic t_pins;
        out_enable <= 1'b0;
        wait_n(2);
        chk("oe off", 0, result_oe);
        out_enable <= 1'b1;
        wait_n(2);
        chk("oe on", 16'hff, result_oe);
    endtask
    task automatic t_abort_irq;
        start_pulse();
        wait_n(4);
        conv(8'hff, "restart result");
        rd(2'h0, 8'h03, "status");
        chk("masked irq", 0, irq);
        wr(2'h1, 8'h01);
        wait_n(2);
        chk("irq", 1, irq);
        wr(2'h0, 8'h03);
        wait_n(2);
        chk("cleared irq", 0, irq);
        rd(2'h1, 8'h01, "mask");
        wr(2'h2, 8'h00);
        rd(2'h2, 8'hff, "result ro");
        rd(2'h3, 8'h00, "unmapped");
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        {nrst, addr_strobe, start, reg_wr, reg_rd, chan_sel, reg_addr, reg_wdata} = '0;
        {mux_enable, out_enable, n_fail, checks} = {2'b11, 64'd0};
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        t_pins();
        t_channels();
        t_mux_off();
        t_abort_irq();
        end_sim();
    end
endmodule
`default_nettype wire
